// File: logic/lp_device.sv
/*
 * converter-side low-power mode controller: unlock latch, the two control bits,
 * the power state machine with its conversion and deep-wake timers, and the ready pin.
 * assumes convert_start_select and writes are synchronous to sys_clk.
 * assumes the host keeps the unlock order and both wake times; a select rise
 * inside the deep wake time is not taken as a conversion start.
 */
`timescale 1ns/1ps
`include "lp_mode_defines.svh"
module lp_device (
    input wire logic sys_clk,
    input wire logic resetn,
    lp_mode_if.device link,
    output logic analog_power_on,
    output logic light_idle_mode,
    output logic deep_sleep_mode,
    output logic converting,
    output logic [7:0] reset_power_control_register
);
    import lp_mode_pkg::*;

    // ==========================================
    // register and unlock
    logic unlocked_reg, unlocked_next;
    logic light_idle_enable_reg, light_idle_enable_next;
    logic deep_sleep_request_reg, deep_sleep_request_next;
    logic select_reg;
    logic ready_reg, ready_next;
    logic ctl_write;
    logic key_write;
    logic select_rise;
    logic select_fall;

    assign ctl_write = link.wr_strobe && (link.wr_addr == `PWRCTL_ADDR);
    assign key_write = link.wr_strobe && (link.wr_addr == `UNLOCK_ADDR);
    assign select_rise = link.convert_start_select && !select_reg;
    assign select_fall = !link.convert_start_select && select_reg;

    always_comb begin
        unlocked_next = unlocked_reg;
        light_idle_enable_next = light_idle_enable_reg;
        deep_sleep_request_next = deep_sleep_request_reg;
        // any value other than the key locks the control bits again
        if (key_write) begin
            unlocked_next = (link.wr_data == `UNLOCK_KEY);
        end else if (ctl_write && unlocked_reg) begin
            light_idle_enable_next = link.wr_data[`LIGHT_IDLE_BIT];
            deep_sleep_request_next = link.wr_data[`DEEP_SLEEP_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            unlocked_reg <= 1'b0;
            light_idle_enable_reg <= 1'b0;
            deep_sleep_request_reg <= 1'b0;
            select_reg <= 1'b0;
        end else begin
            unlocked_reg <= unlocked_next;
            light_idle_enable_reg <= light_idle_enable_next;
            deep_sleep_request_reg <= deep_sleep_request_next;
            select_reg <= link.convert_start_select;
        end
    end

    // ==========================================
    // power state
    power_state_type state_reg, state_next;
    logic conv_load;
    logic conv_done;
    logic deep_wake_load;
    logic deep_wake_done;
    logic waking_reg, waking_next;
    logic power_on_reg;
    logic power_on_next;
    logic idle_flag_reg;
    logic idle_flag_next;
    logic sleep_flag_reg;
    logic sleep_flag_next;
    logic conv_flag_reg;
    logic conv_flag_next;

    wait_counter conv_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .load(conv_load),
        .value(`CNT_W'(`CONV_CYCLES)),
        .done(conv_done)
    );

    wait_counter deep_wake_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .load(deep_wake_load),
        .value(`CNT_W'(`DEEP_WAKE_CYCLES)),
        .done(deep_wake_done)
    );

    // ==========================================
    // state machine
    always_comb begin
        state_next = state_reg;
        conv_load = 1'b0;
        deep_wake_load = 1'b0;
        // deep wake time runs from the clear of the sleep bit
        waking_next = waking_reg && !deep_wake_done;
        ready_next = ready_reg;
        case (state_reg)
            ST_ACTIVE, ST_ACQUIRE: begin
                ready_next = 1'b1;
                if (select_rise && deep_sleep_request_reg) begin
                    state_next = ST_DEEP_SLEEP;
                end else if (select_rise && waking_reg) begin
                    // analog side still powering up: the rise starts nothing
                    state_next = state_reg;
                end else if (select_rise) begin
                    state_next = ST_CONVERT;
                    conv_load = 1'b1;
                    ready_next = 1'b0;
                end
            end
            ST_CONVERT: begin
                ready_next = 1'b0;
                if (conv_done) begin
                    ready_next = 1'b1;
                    // idle entry uses the pin level at the end of conversion
                    if (light_idle_enable_reg && link.convert_start_select) begin
                        state_next = ST_LIGHT_IDLE;
                    end else begin
                        state_next = ST_ACQUIRE;
                    end
                end
            end
            ST_LIGHT_IDLE: begin
                if (select_fall) begin
                    state_next = ST_ACQUIRE;
                end
            end
            ST_DEEP_SLEEP: begin
                ready_next = 1'b1;
                // clearing the sleep bit is the only way out
                if (!deep_sleep_request_reg) begin
                    state_next = ST_ACTIVE;
                    deep_wake_load = 1'b1;
                    waking_next = 1'b1;
                end
            end
            default: begin
                state_next = ST_ACTIVE;
            end
        endcase
        // flags follow state_next so they line up with state_reg
        power_on_next = (state_next != ST_DEEP_SLEEP);
        idle_flag_next = (state_next == ST_LIGHT_IDLE);
        sleep_flag_next = (state_next == ST_DEEP_SLEEP);
        conv_flag_next = (state_next == ST_CONVERT);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_ACTIVE;
            waking_reg <= 1'b0;
            ready_reg <= 1'b1;
            power_on_reg <= 1'b1;
            idle_flag_reg <= 1'b0;
            sleep_flag_reg <= 1'b0;
            conv_flag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            waking_reg <= waking_next;
            ready_reg <= ready_next;
            power_on_reg <= power_on_next;
            idle_flag_reg <= idle_flag_next;
            sleep_flag_reg <= sleep_flag_next;
            conv_flag_reg <= conv_flag_next;
        end
    end

    // ==========================================
    // outputs
    // registers stay in flip-flops on the always-on side in every state
    assign analog_power_on = power_on_reg;
    assign light_idle_mode = idle_flag_reg;
    assign deep_sleep_mode = sleep_flag_reg;
    assign converting = conv_flag_reg;
    // ready low only while a conversion runs
    assign link.ready_indicator_pin = ready_reg;
    always_comb begin
        reset_power_control_register = `PWRCTL_RESET;
        reset_power_control_register[`LIGHT_IDLE_BIT] = light_idle_enable_reg;
        reset_power_control_register[`DEEP_SLEEP_BIT] = deep_sleep_request_reg;
    end
endmodule : lp_device

// File: logic/lp_mode_defines.svh
/*
 * timing counts, key value and register locations for the low-power mode link.
 * assumes a 200 MHz system clock shared by both ends.
 */
`ifndef LP_MODE_DEFINES_SVH
`define LP_MODE_DEFINES_SVH

// ==========================================
// register access
`define UNLOCK_ADDR 8'h05
`define UNLOCK_KEY 8'h69
`define PWRCTL_ADDR 8'h04
`define LIGHT_IDLE_BIT 1
`define DEEP_SLEEP_BIT 0
`define PWRCTL_RESET 8'h00

// ==========================================
// timing, ns and cycles at 5 ns
`define CLK_PERIOD_NS 5
`define CONV_TIME_NS 500
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_WAKE_NS 200
`define IDLE_WAKE_CYCLES ((`IDLE_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEEP_WAKE_NS 2000
`define DEEP_WAKE_CYCLES ((`DEEP_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 12

`endif

// File: logic/lp_mode_pkg.sv
/*
 * types shared by both ends of the low-power mode link.
 * assumes lp_mode_defines.svh for the numbers.
 */
package lp_mode_pkg;
    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_CONVERT,
        ST_ACQUIRE,
        ST_LIGHT_IDLE,
        ST_DEEP_SLEEP
    } power_state_type;
    typedef logic [7:0] byte_type;
endpackage : lp_mode_pkg

// File: logic/lp_mode_if.sv
/*
 * link between host controller and converter device.
 * assumes one sys_clk for both ends; write strobe is high one cycle per write (key and control writes run back to back).
 */
`timescale 1ns/1ps
interface lp_mode_if;
    logic convert_start_select;
    logic wr_strobe;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic ready_indicator_pin;
    modport device (
        input convert_start_select,
        input wr_strobe,
        input wr_addr,
        input wr_data,
        output ready_indicator_pin
    );
    modport host (
        output convert_start_select,
        output wr_strobe,
        output wr_addr,
        output wr_data,
        input ready_indicator_pin
    );
endinterface : lp_mode_if

// File: logic/wait_counter.sv
/*
 * loadable down counter, done when zero and load is low.
 * assumes load has priority over counting.
 */
`timescale 1ns/1ps
`include "lp_mode_defines.svh"
module wait_counter (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [`CNT_W-1:0] value,
    output logic done
);
    logic [`CNT_W-1:0] cnt_reg;
    logic [`CNT_W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = value;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - `CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign done = (cnt_reg == '0) && !load;
endmodule : wait_counter

// File: logic/lp_host.sv
/*
 * host-side sequencer for the converter low-power modes.
 * assumes one command pulse at a time, taken only while busy is low.
 */
`timescale 1ns/1ps
`include "lp_mode_defines.svh"
module lp_host (
    input wire logic sys_clk,
    input wire logic resetn,
    lp_mode_if.host link,
    input wire logic cmd_idle,
    input wire logic cmd_sleep,
    input wire logic cmd_wake,
    input wire logic cmd_convert,
    output logic busy
);
    import lp_mode_pkg::*;

    typedef enum {
        H_IDLE, H_KEY, H_CTL, H_CONV_HI, H_CONV_WAIT, H_FALL, H_WAIT
    } host_state_type;

    host_state_type st_reg, st_next;
    byte_type ctl_reg, ctl_next;
    logic sel_reg, sel_next;
    logic stb_reg, stb_next;
    byte_type addr_reg, addr_next, data_reg, data_next;
    logic [`CNT_W-1:0] cnt_reg, cnt_next;

    always_comb begin
        st_next = st_reg;
        ctl_next = ctl_reg;
        sel_next = sel_reg;
        stb_next = 1'b0;
        addr_next = addr_reg;
        data_next = data_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - `CNT_W'(1) : cnt_reg;
        case (st_reg)
            H_IDLE: begin
                if (cmd_idle || cmd_sleep || cmd_wake) begin
                    ctl_next = ctl_reg;
                    if (cmd_idle) ctl_next[`LIGHT_IDLE_BIT] = 1'b1;
                    if (cmd_sleep) ctl_next[`DEEP_SLEEP_BIT] = 1'b1;
                    if (cmd_wake) ctl_next[`DEEP_SLEEP_BIT] = 1'b0;
                    stb_next = 1'b1;
                    addr_next = `UNLOCK_ADDR;
                    data_next = `UNLOCK_KEY;
                    st_next = H_KEY;
                end else if (cmd_convert) begin
                    if (ctl_reg[`DEEP_SLEEP_BIT]) begin
                        sel_next = 1'b1;  // rising edge puts device to sleep
                        st_next = H_FALL;
                    end else begin
                        sel_next = 1'b1;
                        cnt_next = `CNT_W'(`CONV_CYCLES + 2);
                        st_next = H_CONV_WAIT;
                    end
                end
            end
            H_KEY: begin
                stb_next = 1'b1;
                addr_next = `PWRCTL_ADDR;
                data_next = ctl_reg;
                st_next = H_CTL;
            end
            H_CTL: begin
                // clearing deep sleep starts the device wake-up time
                cnt_next = ctl_reg[`DEEP_SLEEP_BIT] ? '0 : `CNT_W'(`DEEP_WAKE_CYCLES);
                st_next = H_WAIT;
            end
            H_CONV_WAIT: begin
                // select stays high past conversion end so idle is taken
                if (cnt_reg == '0) begin
                    st_next = H_FALL;
                end
            end
            H_FALL: begin
                sel_next = 1'b0;
                cnt_next = `CNT_W'(`IDLE_WAKE_CYCLES);
                st_next = H_WAIT;
            end
            H_WAIT: begin
                if (cnt_reg == '0) begin
                    st_next = H_IDLE;
                end
            end
            default: begin
                st_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= H_IDLE;
            ctl_reg <= `PWRCTL_RESET;
            sel_reg <= 1'b0;
            stb_reg <= 1'b0;
            addr_reg <= 8'h00;
            data_reg <= 8'h00;
            cnt_reg <= '0;
        end else begin
            st_reg <= st_next;
            ctl_reg <= ctl_next;
            sel_reg <= sel_next;
            stb_reg <= stb_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            cnt_reg <= cnt_next;
        end
    end

    assign link.convert_start_select = sel_reg;
    assign link.wr_strobe = stb_reg;
    assign link.wr_addr = addr_reg;
    assign link.wr_data = data_reg;
    assign busy = (st_reg != H_IDLE);
endmodule : lp_host

// File: testbench/lp_mode_properties.sv
/*
 * checker on the link wires; keeps its own copy of unlock and sleep state from the writes.
 * assumes one sys_clk for both ends and the link defines header on the include path.
 */
`timescale 1ns/1ps
`include "lp_mode_defines.svh"
module lp_mode_properties (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic convert_start_select,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic ready_indicator_pin
);
    // ==========================================
    // shadow state and gap counters
    logic unlocked_reg;
    logic deep_reg;
    logic deep_rise_reg;
    logic sel_reg;
    logic [11:0] high_reg;
    logic [11:0] low_reg;
    logic [11:0] wake_reg;
    logic ctl_wr;
    logic rise;
    assign ctl_wr = wr_strobe && wr_addr == `PWRCTL_ADDR && unlocked_reg;
    assign rise = convert_start_select && !sel_reg;
    // counters saturate so a long quiet spell never wraps into a false short gap
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            unlocked_reg <= 1'b0;
            deep_reg <= 1'b0;
            deep_rise_reg <= 1'b0;
            sel_reg <= 1'b0;
            high_reg <= 12'hfff;
            low_reg <= 12'hfff;
            wake_reg <= 12'hfff;
        end else begin
            sel_reg <= convert_start_select;
            if (wr_strobe && wr_addr == `UNLOCK_ADDR) begin
                unlocked_reg <= wr_data == `UNLOCK_KEY;
            end
            if (ctl_wr) begin
                deep_reg <= wr_data[`DEEP_SLEEP_BIT];
            end
            if (rise) begin
                deep_rise_reg <= deep_reg;
            end
            high_reg <= rise ? 12'h000 : high_reg + {11'h000, high_reg != 12'hfff};
            low_reg <= (sel_reg && !convert_start_select) ? 12'h000 : low_reg + {11'h000, low_reg != 12'hfff};
            wake_reg <= (ctl_wr && deep_reg && !wr_data[`DEEP_SLEEP_BIT]) ? 12'h000
                : wake_reg + {11'h000, wake_reg != 12'hfff};
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_unlock_before_ctrl: assert property (wr_strobe && wr_addr == `PWRCTL_ADDR |->
        $past(wr_strobe) && $past(wr_addr) == `UNLOCK_ADDR && $past(wr_data) == `UNLOCK_KEY)
        else $error("control write without key write just before");
    a_conv_drops_ready: assert property (rise && !deep_reg |-> ##[1:3] !ready_indicator_pin)
        else $error("ready did not drop after conversion start");
    a_sleep_holds_ready: assert property (rise && deep_reg |-> ##1 ready_indicator_pin [*8])
        else $error("ready not held high in deep sleep");
    a_wake_raises_ready: assert property (ctl_wr && deep_reg && !wr_data[`DEEP_SLEEP_BIT] |->
        ##[1:2] ready_indicator_pin)
        else $error("ready not high after deep sleep cleared");
    a_idle_wake_gap: assert property (rise |-> low_reg >= `IDLE_WAKE_CYCLES - 1)
        else $error("select raised before idle wake time");
    a_deep_wake_gap: assert property (rise |-> wake_reg >= `DEEP_WAKE_CYCLES - 1)
        else $error("select raised before deep wake time");
    a_select_held_conv: assert property (sel_reg && !convert_start_select && !deep_rise_reg |->
        high_reg >= `CONV_CYCLES)
        else $error("select dropped before conversion end");
    a_ready_low_conv: assert property (!ready_indicator_pin |-> $past(convert_start_select))
        else $error("ready low outside a conversion");
endmodule : lp_mode_properties

// File: testbench/tb_adc_low_power_mode_control.sv
/*
 * testbench: host and device joined by one link, plus a second device driven by the bench.
 * assumes the logic/ files and the defines header are compiled first.
 */
`timescale 1ns/1ps
`include "lp_mode_defines.svh"
module tb_adc_low_power_mode_control;
    import lp_mode_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_idle = 1'b0;
    logic cmd_sleep = 1'b0;
    logic cmd_wake = 1'b0;
    logic cmd_convert = 1'b0;
    logic busy;
    logic analog_power_on;
    logic light_idle_mode;
    logic deep_sleep_mode;
    logic converting;
    logic [7:0] ctl;
    logic [7:0] ctl_b;
    logic ready;
    logic sel;
    int fail_count = 0;
    int n_checks = 0;
    lp_mode_if link();
    lp_mode_if link_b();
    always #2.5 sys_clk = ~sys_clk;
    always_comb ready = link.ready_indicator_pin;
    always_comb sel = link.convert_start_select;
    lp_host u_lp_host (.sys_clk(sys_clk), .resetn(resetn), .link(link.host), .cmd_idle(cmd_idle),
        .cmd_sleep(cmd_sleep), .cmd_wake(cmd_wake), .cmd_convert(cmd_convert), .busy(busy));
    lp_device u_lp_device (.sys_clk(sys_clk), .resetn(resetn), .link(link.device),
        .analog_power_on(analog_power_on), .light_idle_mode(light_idle_mode),
        .deep_sleep_mode(deep_sleep_mode), .converting(converting), .reset_power_control_register(ctl));
    lp_device u_lp_device_b (.sys_clk(sys_clk), .resetn(resetn), .link(link_b.device), .analog_power_on(),
        .light_idle_mode(), .deep_sleep_mode(), .converting(), .reset_power_control_register(ctl_b));
    lp_mode_properties u_lp_mode_properties (.sys_clk(sys_clk), .resetn(resetn),
        .convert_start_select(link.convert_start_select), .wr_strobe(link.wr_strobe),
        .wr_addr(link.wr_addr), .wr_data(link.wr_data), .ready_indicator_pin(link.ready_indicator_pin));
    // ==========================================
    // shared tasks
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_for(ref logic s, input logic lvl, input int limit);
        for (int i = 0; i < limit && s !== lvl; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (s !== lvl) begin
            fail_count++;
            $display("mismatch at %0t: wait got %h expected %h", $time, s, lvl);
            wrap_up();
        end
    endtask : wait_for
    task automatic cmd(input int which);
        wait_for(busy, 1'b0, 1000);
        @(posedge sys_clk);
        {cmd_idle, cmd_sleep, cmd_wake, cmd_convert} <= 4'h8 >> which;
        @(posedge sys_clk);
        {cmd_idle, cmd_sleep, cmd_wake, cmd_convert} <= 4'h0;
        // let the host's state settle so busy shows the command just taken
        #1;
    endtask : cmd
    // released lines show the inverse so a late sample cannot pass
    task automatic bwrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {link_b.wr_strobe, link_b.wr_addr, link_b.wr_data} <= {1'b1, a, d};
        @(posedge sys_clk);
        {link_b.wr_strobe, link_b.wr_addr, link_b.wr_data} <= {1'b0, ~a, ~d};
    endtask : bwrite
    // ==========================================
    // scenarios
    task automatic t_convert;
        cmd(3);
        wait_for(converting, 1'b1, 10);
        chk(8'(analog_power_on), 8'h01);
        wait_for(converting, 1'b0, 200);
        chk(8'(light_idle_mode), 8'h00);
        chk(8'(analog_power_on), 8'h01);
        wait_for(busy, 1'b0, 300);
        $display("t_convert done");
    endtask : t_convert
    task automatic t_light_idle;
        cmd(0);
        // the host also waits the deep wake time after arming idle
        wait_for(busy, 1'b0, 600);
        chk(8'(ctl[`LIGHT_IDLE_BIT]), 8'h01);
        cmd(3);
        wait_for(light_idle_mode, 1'b1, 300);
        chk(8'(sel), 8'h01);
        wait_for(light_idle_mode, 1'b0, 20);
        chk(8'(sel), 8'h00);
        wait_for(busy, 1'b0, 300);
        $display("t_light_idle done");
    endtask : t_light_idle
    task automatic t_deep;
        cmd(1);
        wait_for(busy, 1'b0, 300);
        if (!deep_sleep_mode) begin
            cmd(3);
        end
        wait_for(deep_sleep_mode, 1'b1, 50);
        chk(8'(ready), 8'h01);
        chk(8'(analog_power_on), 8'h00);
        chk(8'(ctl[`DEEP_SLEEP_BIT]), 8'h01);
        cmd(2);
        wait_for(deep_sleep_mode, 1'b0, 50);
        chk(8'(ready), 8'h01);
        chk(8'(ctl[`DEEP_SLEEP_BIT]), 8'h00);
        cmd(3);
        wait_for(converting, 1'b1, 1000);
        chk(8'(analog_power_on), 8'h01);
        wait_for(busy, 1'b0, 1000);
        $display("t_deep done");
    endtask : t_deep
    task automatic t_lock;
        bwrite(`PWRCTL_ADDR, 8'h03);
        @(posedge sys_clk);
        #1;
        chk(ctl_b, `PWRCTL_RESET);
        bwrite(`UNLOCK_ADDR, `UNLOCK_KEY);
        bwrite(`PWRCTL_ADDR, 8'h02);
        bwrite(`PWRCTL_ADDR, 8'h03);
        @(posedge sys_clk);
        #1;
        chk(ctl_b, 8'h03);
        bwrite(`UNLOCK_ADDR, 8'h12);
        bwrite(`PWRCTL_ADDR, 8'h00);
        @(posedge sys_clk);
        #1;
        chk(ctl_b, 8'h03);
        $display("t_lock done");
    endtask : t_lock
    initial begin
        link_b.convert_start_select = 1'b0;
        link_b.wr_strobe = 1'b0;
        link_b.wr_addr = 8'h00;
        link_b.wr_data = 8'h00;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        t_convert();
        t_light_idle();
        t_deep();
        t_lock();
        wrap_up();
    end
endmodule : tb_adc_low_power_mode_control
